// ### design/cdc_defs.vh
// Register offsets, field positions, reset values and timing for the comparator DAC control block.
`ifndef CDC_DEFS_VH
`define CDC_DEFS_VH
`define CDC_ADDR_W        4
`define CDC_OFF_COMMON    4'h0
`define CDC_OFF_STEADY    4'h1
`define CDC_OFF_TRANS     4'h2
`define CDC_OFF_BLANK0    4'h4
`define CDC_OFF_CTRL0     4'h8
`define CDC_OFF_EVENT     4'hc
`define CDC_NCH           3
`define CDC_BIT_ON        15
`define CDC_BIT_SIDL      13
`define CDC_BIT_CHEN      15
`define CDC_BIT_INTERRUPT_EDGE_MODE_HI   14
`define CDC_BIT_INTERRUPT_EDGE_MODE_LO   13
`define CDC_BIT_CBE       10
`define CDC_BIT_OEN       9
`define CDC_BIT_FLT       8
`define CDC_BIT_STAT      7
`define CDC_BIT_POL       6
`define CDC_RST_STEADY    10'h08a
`define CDC_RST_TRANS     10'h055
`define CDC_COMMON_MASK   16'ha0f7
`define CDC_CTRL_MASK     16'he77f
`define CDC_FLT_LEN       3
`endif

// ### design/cdc_converter_clock_divider.v
// Programmable divider producing a one-cycle enable pulse every N input enables.
`timescale 1ns/1ps
`default_nettype none
module cdc_converter_clock_divider
(
  // Clock and reset.
  input  wire       clk_i,
  input  wire       rst_n_i,
  // Control.
  input  wire       run_i,
  input  wire       en_i,
  input  wire [3:0] ratio_i,
  // Output tick.
  output reg        tick_o
);
  reg [3:0] cnt_ff;

  // Counter wraps at the ratio; a ratio of one passes every input enable.
  always @(posedge clk_i)
  begin
    if (!rst_n_i || !run_i)
    begin
      cnt_ff <= 4'h0;
      tick_o <= 1'b0;
    end
    else if (en_i)
    begin
      if (cnt_ff + 4'h1 >= ratio_i)
      begin
        cnt_ff <= 4'h0;
        tick_o <= 1'b1;
      end
      else
      begin
        cnt_ff <= cnt_ff + 4'h1;
        tick_o <= 1'b0;
      end
    end
    else
      tick_o <= 1'b0;
  end
endmodule // cdc_converter_clock_divider
`default_nettype wire

// ### design/cdc_top.v
// Comparator DAC control: common clocking, filter timing and per-channel control.
// Operation
// [R01] Common enable low stops all channels, filter clocks, clears slope/underflow.
// [R02] Idle-stop set halts comparator and DAC operation during chip Idle.
// [R03] Clock source: 11 main PLL, 10 aux PLL, 01 main VCO/2, 00 aux VCO/2.
// [R04] Converter divider: 00 by 1, 01 by 2, 10 by 3, 11 by 4.
// [R05] Filter divider: 000 by 1, 001 by 2, 010..111 by 3..8.
// [R06] Filter divider input is the selected source divided by two.
// [R07] Software changes clock fields only while common enable is 0.
// [R08] Software picks source and divider giving an effective 500 MHz.
// [R09] Steady-state delay sets time to steady filter; reset value 0x08a.
// [R10] Transition duration sets fast-mode length; reset value 0x055.
// [R11] Software keeps steady-state delay above transition duration.
// [R12] Per-channel blanking count blanks output after hysteretic-input change.
// [R13] Channel enable low disables channel, clears its slope and underflow.
// [R14] Edge mode: 00 off, 01 rising, 10 falling, 11 either edge.
// [R15] Edge detection acts on the polarity-corrected comparator output.
// [R16] Edge-mode changes while running may cause a spurious event.
// [R17] Post-slope blank enable gates output during recovery after slope.
// [R18] Digital filter enable switches the output filter in or bypasses it.
// [R19] Comparator state bit reads current output with polarity applied.
// [R20] Output invert bit inverts the comparator output when set.
// [R21] Input select 000..011 routes inputs A..D; 100..111 reserved.
// [R22] Hysteresis edge bit picks falling or rising; amount none/15/30/45 mV.
// [R23] Hysteretic-control edges start blanking and switch DAC high/low limit.
// [R24] Comparator output is synchronised before status and edge detection.
`timescale 1ns/1ps
`default_nettype none
`include "cdc_defs.vh"
module cdc_top
(
  // Clock and reset.
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Register port.
  input  wire [3:0]  addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [15:0] rdata_o,
  // Chip state and source clock enables (one per source, main-clock pulses).
  input  wire        idle_i,
  input  wire [3:0]  src_tick_i,
  // Per-channel analog and system inputs.
  input  wire [2:0]  cmp_raw_i,
  input  wire [2:0]  hyst_ctrl_i,
  input  wire [2:0]  slope_done_i,
  // Clock enables to the converters.
  output reg         conv_tick_o,
  output reg         filt_tick_o,
  // Filter phase outputs.
  output reg         trans_mode_o,
  output reg         steady_mode_o,
  // Per-channel analog controls.
  output reg  [2:0]  chan_run_o,
  output reg  [2:0]  chan_clear_o,
  output reg  [5:0]  input_select_o,
  output reg  [2:0]  hyst_edge_o,
  output reg  [5:0]  hyst_amount_o,
  output reg  [2:0]  out_buf_en_o,
  output reg  [2:0]  use_high_limit_o,
  // Per-channel comparator output and event.
  output reg  [2:0]  cmp_out_o,
  output reg  [2:0]  cmp_event_o
);
  // Shared software registers.
  reg  [15:0] common_ff;
  reg  [9:0]  steady_ff;
  reg  [9:0]  trans_ff;
  reg  [9:0]  blank_ff [0:2];
  reg  [15:0] ctrl_ff  [0:2];
  reg  [2:0]  evt_ff;
  reg  [9:0]  phase_cnt_ff;
  reg         half_ff;
  wire [2:0]  nxt_evt;
  wire [2:0]  stat_w;
  wire        common_on;
  wire        run_all;
  wire        sel_tick;
  wire        conv_tick_w;
  wire        filt_tick_w;
  wire [3:0]  conv_ratio;
  wire [3:0]  filt_ratio;
  reg  [15:0] nxt_rdata;
  integer     k;
  integer     j;

  // Decodes a register index to a per-channel slot or 3 for no match.
  function [1:0] ch_of;
    input [3:0] a;
    input [3:0] base;
    begin
      if (a == base)
        ch_of = 2'd0;
      else if (a == base + 4'h1)
        ch_of = 2'd1;
      else if (a == base + 4'h2)
        ch_of = 2'd2;
      else
        ch_of = 2'd3;
    end
  endfunction

  assign common_on = common_ff[`CDC_BIT_ON];
  // Idle stop halts all activity only while the chip idles.
  assign run_all = common_on & ~(common_ff[`CDC_BIT_SIDL] & idle_i); // [R01] [R02]
  // Source mux: code 3 main PLL through code 0 aux VCO half.
  assign sel_tick = src_tick_i[common_ff[7:6]]; // [R03]
  // Divider ratio equals code plus one.
  assign conv_ratio = {2'b00, common_ff[5:4]} + 4'h1; // [R04]
  // Code 001 is taken as divide by two; every code is then code plus one.
  assign filt_ratio = {1'b0, common_ff[2:0]} + 4'h1; // [R05]

  // Prescale by two ahead of the filter divider.
  always @(posedge clk_i)
  begin
    if (!rst_n_i || !run_all)
      half_ff <= 1'b0;
    else if (sel_tick)
      half_ff <= ~half_ff; // [R06]
  end

  // Converter clock divider; the by-three duty skew is inherent to a tick.
  cdc_converter_clock_divider u_conv_div
  (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .run_i   (run_all),
    .en_i    (sel_tick),
    .ratio_i (conv_ratio),
    .tick_o  (conv_tick_w)
  );

  // Filter clock divider fed by the halved source; stopped when disabled.
  cdc_converter_clock_divider u_filt_div
  (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .run_i   (run_all),
    .en_i    (sel_tick & half_ff),
    .ratio_i (filt_ratio),
    .tick_o  (filt_tick_w)
  );

  // Filter phase timer, counted in converter ticks from enable.
  always @(posedge clk_i)
  begin
    if (!rst_n_i || !run_all)
    begin
      phase_cnt_ff  <= 10'h000;
      trans_mode_o  <= 1'b0;
      steady_mode_o <= 1'b0;
      conv_tick_o   <= 1'b0;
      filt_tick_o   <= 1'b0;
    end
    else
    begin
      conv_tick_o  <= conv_tick_w;
      filt_tick_o  <= filt_tick_w; // [R01]
      if (conv_tick_w && phase_cnt_ff != 10'h3ff)
        phase_cnt_ff <= phase_cnt_ff + 10'h001;
      trans_mode_o  <= (phase_cnt_ff < trans_ff); // [R10]
      steady_mode_o <= (phase_cnt_ff >= steady_ff); // [R09]
    end
  end

  // Register writes; fields kept only where bits are implemented.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      common_ff <= 16'h0000;
      steady_ff <= `CDC_RST_STEADY; // [R09]
      trans_ff  <= `CDC_RST_TRANS; // [R10]
      for (j = 0; j < `CDC_NCH; j = j + 1)
      begin
        blank_ff[j] <= 10'h000;
        ctrl_ff[j]  <= 16'h0000;
      end
    end
    else if (wr_i)
    begin
      if (addr_i == `CDC_OFF_COMMON)
        common_ff <= wdata_i & `CDC_COMMON_MASK;
      else if (addr_i == `CDC_OFF_STEADY)
        steady_ff <= wdata_i[9:0];
      else if (addr_i == `CDC_OFF_TRANS)
        trans_ff <= wdata_i[9:0];
      else if (ch_of(addr_i, `CDC_OFF_BLANK0) != 2'd3)
        blank_ff[ch_of(addr_i, `CDC_OFF_BLANK0)] <= wdata_i[9:0]; // [R12]
      else if (ch_of(addr_i, `CDC_OFF_CTRL0) != 2'd3)
        ctrl_ff[ch_of(addr_i, `CDC_OFF_CTRL0)] <= wdata_i
          & `CDC_CTRL_MASK;
    end
  end

  // Per-channel comparator path.
  genvar g;
  generate
    for (g = 0; g < `CDC_NCH; g = g + 1)
    begin : g_ch
      reg  [2:0] sync_ff;
      reg  [2:0] flt_ff;
      reg        clean_ff;
      reg        prev_ff;
      reg        hyst_s1_ff;
      reg        hyst_s2_ff;
      reg        hyst_s3_ff;
      reg  [9:0] blank_cnt_ff;
      reg        rec_ff;
      wire       ch_run;
      wire       pol;
      wire       stable;
      wire       filtered;
      wire       gated;
      wire [1:0] interrupt_edge_mode;
      wire       hyst_edge;

      assign ch_run = run_all & ctrl_ff[g][`CDC_BIT_CHEN]; // [R13]
      assign interrupt_edge_mode   = ctrl_ff[g][`CDC_BIT_INTERRUPT_EDGE_MODE_HI:`CDC_BIT_INTERRUPT_EDGE_MODE_LO];
      // The raw pin lands in sync_ff[0]; only sync_ff[1] reads it.
      assign stable = (sync_ff[1] == sync_ff[2]); // [R24]
      assign pol    = sync_ff[2] ^ ctrl_ff[g][`CDC_BIT_POL]; // [R20]
      assign hyst_edge = (hyst_s2_ff == hyst_s3_ff) &
                         (hyst_s3_ff != use_high_limit_o[g]);
      // On the filter clock the filter reloads only the level it already holds, so it stays at its cleared low level.
      assign filtered = ctrl_ff[g][`CDC_BIT_FLT] ?
                        flt_ff[`CDC_FLT_LEN-1] : pol; // [R18]
      assign gated = filtered & (blank_cnt_ff == 10'h000) &
                     ~(rec_ff & ctrl_ff[g][`CDC_BIT_CBE]); // [R17] [R12]
      assign stat_w[g] = clean_ff; // [R19]
      // Edge select on polarity-corrected output; mode changes may glitch.
      assign nxt_evt[g] = ch_run & (
        (interrupt_edge_mode[0] & clean_ff & ~prev_ff) |
        (interrupt_edge_mode[1] & ~clean_ff & prev_ff)); // [R14] [R15] [R16]

      // Synchronisers, filter, blanking and the edge history.
      always @(posedge clk_i)
      begin
        if (!rst_n_i)
        begin
          sync_ff      <= 3'b000;
          hyst_s1_ff   <= 1'b0;
          hyst_s2_ff   <= 1'b0;
          hyst_s3_ff   <= 1'b0;
          flt_ff       <= 3'b000;
          clean_ff     <= 1'b0;
          prev_ff      <= 1'b0;
          blank_cnt_ff <= 10'h000;
          rec_ff       <= 1'b0;
        end
        else
        begin
          sync_ff    <= {sync_ff[1:0], cmp_raw_i[g]};
          hyst_s1_ff <= hyst_ctrl_i[g];
          hyst_s2_ff <= hyst_s1_ff;
          hyst_s3_ff <= hyst_s2_ff;
          if (!ch_run)
          begin
            flt_ff       <= 3'b000;
            blank_cnt_ff <= 10'h000;
            rec_ff       <= 1'b0;
          end
          else
          begin
            if (filt_tick_w && stable)
              flt_ff <= (&{flt_ff[1:0], pol} || ~|{flt_ff[1:0], pol}) ?
                        {3{pol}} : flt_ff;
            if (hyst_edge)
              blank_cnt_ff <= blank_ff[g]; // [R23]
            else if (blank_cnt_ff != 10'h000)
              blank_cnt_ff <= blank_cnt_ff - 10'h001;
            // Recovery window: steady filter not yet back after a slope.
            if (slope_done_i[g])
              rec_ff <= 1'b1;
            else if (steady_mode_o)
              rec_ff <= 1'b0;
          end
          if (stable)
            clean_ff <= gated;
          prev_ff <= clean_ff;
        end
      end
    end
  endgenerate

  // Sticky events; a new event wins over the clear write.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      evt_ff <= 3'b000;
    else if (wr_i && addr_i == `CDC_OFF_EVENT)
      evt_ff <= (evt_ff & ~wdata_i[2:0]) | nxt_evt;
    else
      evt_ff <= evt_ff | nxt_evt;
  end

  // Per-channel outputs, all registered.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      chan_run_o       <= 3'b000;
      chan_clear_o     <= 3'b111;
      input_select_o   <= 6'h00;
      hyst_edge_o      <= 3'b000;
      hyst_amount_o    <= 6'h00;
      out_buf_en_o     <= 3'b000;
      use_high_limit_o <= 3'b000;
      cmp_out_o        <= 3'b000;
      cmp_event_o      <= 3'b000;
    end
    else
    begin
      for (k = 0; k < `CDC_NCH; k = k + 1)
      begin
        chan_run_o[k]   <= run_all & ctrl_ff[k][`CDC_BIT_CHEN];
        // Clear slope and underflow while either enable is off.
        chan_clear_o[k] <= ~(common_on & ctrl_ff[k][`CDC_BIT_CHEN]); // [R01] [R13]
        // Reserved selects park on input A to keep the mux defined.
        input_select_o[2*k +: 2] <= ctrl_ff[k][5] ? 2'b00 :
                                    ctrl_ff[k][4:3]; // [R21]
        hyst_edge_o[k]  <= ctrl_ff[k][2]; // [R22]
        hyst_amount_o[2*k +: 2] <= ctrl_ff[k][1:0]; // [R22]
        out_buf_en_o[k] <= ctrl_ff[k][`CDC_BIT_OEN];
        use_high_limit_o[k] <= g_hl(k); // [R23]
        cmp_out_o[k]    <= stat_w[k];
        cmp_event_o[k]  <= nxt_evt[k];
      end
    end
  end

  // Picks the synchronised hysteretic input of a channel.
  function g_hl;
    input integer c;
    begin
      if (c == 0)
        g_hl = g_ch[0].hyst_s3_ff;
      else if (c == 1)
        g_hl = g_ch[1].hyst_s3_ff;
      else
        g_hl = g_ch[2].hyst_s3_ff;
    end
  endfunction

  // Read mux; unmapped addresses read zero.
  always @*
  begin
    nxt_rdata = 16'h0000;
    if (addr_i == `CDC_OFF_COMMON)
      nxt_rdata = common_ff;
    else if (addr_i == `CDC_OFF_STEADY)
      nxt_rdata = {6'h00, steady_ff};
    else if (addr_i == `CDC_OFF_TRANS)
      nxt_rdata = {6'h00, trans_ff};
    else if (ch_of(addr_i, `CDC_OFF_BLANK0) != 2'd3)
      nxt_rdata = {6'h00, blank_ff[ch_of(addr_i, `CDC_OFF_BLANK0)]};
    else if (ch_of(addr_i, `CDC_OFF_CTRL0) != 2'd3)
    begin
      nxt_rdata = ctrl_ff[ch_of(addr_i, `CDC_OFF_CTRL0)];
      nxt_rdata[`CDC_BIT_STAT] = stat_w[ch_of(addr_i, `CDC_OFF_CTRL0)]; // [R19]
    end
    else if (addr_i == `CDC_OFF_EVENT)
      nxt_rdata = {13'h0, evt_ff};
  end

  // Read data stands only in the cycle after the strobe.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_o <= 16'h0000;
    else if (rd_i)
      rdata_o <= nxt_rdata;
    else
      rdata_o <= 16'h0000;
  end
endmodule // cdc_top
`default_nettype wire

// ### verification/cdc_checker_assertions.sv
// Port checker for the comparator DAC control block.
`timescale 1ns/1ps
`default_nettype none
module cdc_checker
(
  // Clock, reset and register port.
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  // Observed outputs.
  input wire logic        conv_tick_o,
  input wire logic        filt_tick_o,
  input wire logic        trans_mode_o,
  input wire logic        steady_mode_o,
  input wire logic [2:0]  chan_run_o,
  input wire logic [2:0]  chan_clear_o,
  input wire logic [2:0]  cmp_out_o,
  input wire logic [2:0]  cmp_event_o
);
  logic       on_ff;
  logic [1:0] interrupt_edge_mode_ff;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Shadows of what software wrote, since the register bodies are hidden.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      on_ff   <= 1'b0;
      interrupt_edge_mode_ff <= 2'h0;
    end
    else if (wr_i && addr_i == 4'h0)
      on_ff <= wdata_i[15];
    else if (wr_i && addr_i == 4'h8)
      interrupt_edge_mode_ff <= wdata_i[14:13];
  end
  // Reset must be checked while reset is active, so it is never disabled.
  reset_state_a: assert property (disable iff (1'b0) !rst_n_i |=>
    chan_clear_o == 3'h7 && chan_run_o == 3'h0 && rdata_o == 16'h0)
    else $error("outputs not at reset values");
  idle_read_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0)
    else $error("read data outside its cycle");
  unmapped_read_a: assert property (rd_i && addr_i == 4'h3 |=>
    rdata_o == 16'h0) else $error("hole read not zero");
  steady_back_a: assert property (wr_i && addr_i == 4'h1 ##2
    rd_i && addr_i == 4'h1 |=> rdata_o == {6'h0, $past(wdata_i[9:0], 3)})
    else $error("steady delay readback wrong");
  run_clear_a: assert property ((chan_run_o & chan_clear_o) == 3'h0)
    else $error("channel running while cleared");
  common_off_a: assert property ((!on_ff)[*4] |-> !conv_tick_o &&
    !filt_tick_o && !trans_mode_o && !steady_mode_o && chan_run_o == 3'h0)
    else $error("activity while common enable off");
  edge_off_a: assert property ((interrupt_edge_mode_ff == 2'h0)[*3] |->
    !cmp_event_o[0]) else $error("event with edge mode off");
  rise_only_a: assert property ((interrupt_edge_mode_ff == 2'h1)[*4] ##0
    cmp_event_o[0] |-> ##[0:3] cmp_out_o[0]) else $error("rise event wrong");
  mode_excl_a: assert property (!(trans_mode_o && steady_mode_o))
    else $error("transition and steady both on");
endmodule // cdc_checker
bind cdc_top cdc_checker cdc_checker_i
(
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conv_tick_o(conv_tick_o),
  .filt_tick_o(filt_tick_o), .trans_mode_o(trans_mode_o),
  .steady_mode_o(steady_mode_o), .chan_run_o(chan_run_o),
  .chan_clear_o(chan_clear_o), .cmp_out_o(cmp_out_o),
  .cmp_event_o(cmp_event_o)
);
`default_nettype wire

// ### verification/comparator_dac_control_tb_top.sv
// Self-checking bench for the comparator DAC control block.
`timescale 1ns/1ps
`default_nettype none
module comparator_dac_control_tb_top;
  // Stimulus and observed outputs.
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        idle_i = 1'b0;
  logic [3:0]  src_tick_i = 4'h0;
  logic [2:0]  cmp_raw_i = 3'h0;
  logic [15:0] rdata_o;
  logic        conv_tick_o, filt_tick_o, trans_mode_o, steady_mode_o;
  logic [2:0]  chan_run_o, chan_clear_o, hyst_edge_o, out_buf_en_o;
  logic [2:0]  cmp_out_o, cmp_event_o;
  logic [5:0]  input_select_o, hyst_amount_o;
  logic [2:0]  hyst_i = 3'h0;
  logic [2:0]  sd_i = 3'h0;
  logic [2:0]  use_high_limit_o;
  int          bad_count = 0;
  int          checks_done = 0;
  int          cc, fc, ec, nc;
  logic [15:0] rv;
  logic [3:0]  ra [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
  logic [15:0] wv [6] = '{16'h7fff, 16'hffff, 16'hfdfe, 16'hffff,
                          16'hffff, 16'hffbf};
  logic [15:0] wx [6] = '{16'h20f7, 16'h03ff, 16'h01fe, 16'h0000,
                          16'h03ff, 16'he73f};
  // Clock at 40 MHz.
  always #12.5 clk_i = ~clk_i;
  // The hysteretic and slope inputs are driven only by the blanking test.
  cdc_top cdc_top_i
  (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .idle_i(idle_i),
    .src_tick_i(src_tick_i), .cmp_raw_i(cmp_raw_i), .hyst_ctrl_i(hyst_i),
    .slope_done_i(sd_i), .conv_tick_o(conv_tick_o),
    .filt_tick_o(filt_tick_o), .trans_mode_o(trans_mode_o),
    .steady_mode_o(steady_mode_o), .chan_run_o(chan_run_o),
    .chan_clear_o(chan_clear_o), .input_select_o(input_select_o),
    .hyst_edge_o(hyst_edge_o), .hyst_amount_o(hyst_amount_o),
    .out_buf_en_o(out_buf_en_o), .use_high_limit_o(use_high_limit_o),
    .cmp_out_o(cmp_out_o), .cmp_event_o(cmp_event_o)
  );
  // Compare one value against its expectation.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One write cycle, then an idle cycle so strobes never double up.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    @(posedge clk_i);
  endtask
  // One read cycle; the data stand only in the following cycle.
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
    @(posedge clk_i);
  endtask
  // Count ticks, events and gap cycles over n cycles, sampled off the edge.
  task automatic cnt(input int n);
    cc = 0;
    fc = 0;
    ec = 0;
    nc = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      #1;
      cc += conv_tick_o;
      fc += filt_tick_o;
      ec += cmp_event_o[0];
      nc += !trans_mode_o && !steady_mode_o;
    end
    @(posedge clk_i);
  endtask
  task automatic done(input string s);
    $display("test %s ended: %0d checks, %0d wrong", s, checks_done,
             bad_count);
  endtask
  task automatic report_and_stop;
    $display("checks_done %0d, bad_count %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Guard against a hung run.
  initial
  begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    report_and_stop();
  end
  // Main sequence.
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk(16'(chan_clear_o), 16'h7);
    for (int i = 0; i < 6; i++)
    begin
      rd(ra[i], rv);
      chk(rv, i == 1 ? 16'h008a : (i == 2 ? 16'h0055 : 16'h0));
      wr(ra[i], wv[i]);
      rd(ra[i], rv);
      chk(rv, wx[i]);
    end
    done("registers");
    for (int i = 0; i < 8; i++)
    begin
      wr(4'h8, {6'h0, i[0], 3'h0, i[2:0], i[0], i[1:0]});
      cnt(2);
      chk(16'({out_buf_en_o[0], input_select_o[1:0], hyst_edge_o[0],
               hyst_amount_o[1:0]}), 16'({i[0], i[2] ? 2'h0 : i[1:0],
               i[0], i[1:0]}));
    end
    done("fields");
    // Fields change only while disabled, so each setting is staged twice.
    // One source ticking every cycle stands in for the 500 MHz rate.
    src_tick_i <= 4'h1;
    for (int k = 0; k < 8; k++)
    begin
      wr(4'h0, {10'h0, k[1:0], 1'b0, k[2:0]});
      wr(4'h0, {1'b1, 9'h0, k[1:0], 1'b0, k[2:0]});
      cnt(20);
      cnt(1680);
      chk(16'(cc), 16'(1680 / (k % 4 + 1)));
      chk(16'(fc), 16'(1680 / (2 * k + 2)));
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(4'h0, 16'(c << 6));
      wr(4'h0, 16'(c << 6) | 16'h8000);
      src_tick_i <= 4'h1 << c;
      cnt(48);
      chk(16'(cc), 16'h30);
      src_tick_i <= ~(4'h1 << c);
      cnt(8);
      cnt(48);
      chk(16'(cc), 16'h0);
    end
    src_tick_i <= 4'hf;
    wr(4'h0, 16'ha0c0);
    idle_i <= 1'b1;
    cnt(8);
    cnt(48);
    chk(16'(cc + fc), 16'h0);
    idle_i <= 1'b0;
    cnt(8);
    cnt(48);
    chk(16'(cc), 16'h30);
    wr(4'h0, 16'h00c0);
    cnt(8);
    cnt(48);
    chk(16'(cc + fc), 16'h0);
    done("clocks");
    // Ticks are held off while enabling, so the timer starts in the window.
    for (int t = 0; t < 2; t++)
    begin
      src_tick_i <= 4'h0;
      wr(4'h0, 16'h0);
      wr(4'h2, 16'(4 + t));
      wr(4'h1, 16'(10 - 3 * t));
      wr(4'h0, 16'h8000);
      cnt(4);
      chk(16'({steady_mode_o, trans_mode_o}), 16'h1);
      src_tick_i <= 4'h1;
      cnt(40);
      chk(16'(nc), 16'(6 - 4 * t));
      chk(16'({steady_mode_o, trans_mode_o}), 16'h2);
    end
    done("phases");
    for (int m = 0; m < 8; m++)
    begin
      cmp_raw_i <= 3'h0;
      wr(4'h8, {1'b1, m[1:0], 6'h0, m[2], 6'h0});
      cnt(12);
      chk(16'({chan_run_o[0], chan_clear_o[0], cmp_out_o[0]}),
          16'({2'b10, m[2]}));
      cmp_raw_i <= 3'h7;
      cnt(12);
      chk(16'(ec), 16'(m[2] ? m[1] : m[0]));
      rd(4'h8, rv);
      chk(16'(rv[7]), 16'(!m[2]));
      cmp_raw_i <= 3'h0;
      cnt(12);
      chk(16'(ec), 16'(m[2] ? m[0] : m[1]));
    end
    // Blanking after a hysteretic edge, then after a slope.
    wr(4'h4, 16'h0014);
    wr(4'h8, 16'h8400);
    cmp_raw_i <= 3'h7;
    cnt(12);
    chk(16'(cmp_out_o[0]), 16'h1);
    hyst_i <= 3'h1;
    cnt(8);
    chk(16'({use_high_limit_o[0], cmp_out_o[0]}), 16'h2);
    cnt(24);
    chk(16'(cmp_out_o[0]), 16'h1);
    wr(4'h0, 16'h0);
    src_tick_i <= 4'h0;
    wr(4'h0, 16'h8000);
    sd_i <= 3'h1;
    @(posedge clk_i);
    sd_i <= 3'h0;
    cnt(8);
    chk(16'({steady_mode_o, cmp_out_o[0]}), 16'h0);
    src_tick_i <= 4'h1;
    cnt(24);
    chk(16'({steady_mode_o, cmp_out_o[0]}), 16'h3);
    // Sticky event flags: channel 0 saw edges, a write of one clears.
    rd(4'hc, rv);
    chk(rv, 16'h1);
    wr(4'hc, 16'h1);
    rd(4'hc, rv);
    chk(rv, 16'h0);
    wr(4'h8, 16'h0);
    cnt(2);
    chk(16'({chan_run_o[0], chan_clear_o[0]}), 16'h1);
    done("comparator");
    report_and_stop();
  end
endmodule // comparator_dac_control_tb_top
`default_nettype wire
